/* tks_slot_ctrl.sv */
// touch key scan slot control slice with classic wishbone slave
//
// Implementation choices: the register addresses and register access over Wishbone.
module tks_slot_ctrl (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_sys_rst,
    // wishbone slave request
    input  wire tks_pkg::tks_wb_req_s i_wb_req,
    // wishbone slave answer
    output logic [31:0]               o_wb_dat,
    output logic                      o_wb_ack,
    // scan status to the touch unit
    output logic                      o_scan_busy_flag,
    output logic                      o_slot_overflow_flag,
    output logic [1:0]                o_slot,
    output logic [1:0]                o_scan_key,
    output logic                      o_key_osc_enable,
    output logic                      o_ref_osc_enable,
    // interrupt
    output logic                      o_irq
);
    import tks_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]  mod1_q;          // keys, koen, roen
    logic [7:0]  slot_q;          // slot key select
    logic        start_q;         // scan start bit
    logic        mode_q;          // scan mode select
    logic        busy_q;          // scan busy flag
    logic        ovf_q;           // slot overflow flag
    logic        busy_prev_q;     // busy history for fall detect
    logic        start_prev_q;    // start history for rise detect
    logic [1:0]  slot_q2;         // current slot index
    logic [7:0]  dwell_q;         // cycles left in slot
    logic [1:0]  ev_q;            // sticky events
    logic [1:0]  mask_q;          // event mask
    tks_state_e  st_q;
    logic        ack_q;

    // bus decode
    logic        acc;             // new access this cycle
    logic        wr;
    logic [4:0]  ofs;
    logic        start_rise;
    logic        busy_fall;

    // key chosen for a slot from the select field
    function automatic logic [1:0] slot_key(input logic [7:0] sel, input logic [1:0] s);
        slot_key = sel[2*s +: 2];
    endfunction

    // a request is taken while ack is low; ack answers it one cycle later
    assign acc        = i_wb_req.cyc & i_wb_req.stb & ~ack_q;
    // writes commit on the edge where the master samples ack, not on the taking edge,
    // so a master waiting for ack never sees a register change ahead of it
    assign wr         = i_wb_req.cyc & i_wb_req.stb & ack_q & i_wb_req.we & i_wb_req.sel[0];
    assign ofs        = i_wb_req.adr[4:0];
    assign start_rise = start_q & ~start_prev_q;
    assign busy_fall  = busy_prev_q & ~busy_q;

    // ************************************************************
    // bus answer: ack one cycle after request, dropped next cycle
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ack_q    <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            ack_q    <= acc;
            o_wb_dat <= 32'h0000_0000;
            // read mux loads every edge; it only matters while ack stands
            // unmapped offsets read as zero
            unique case (ofs)
                {1'b0, TKS_OFS_CTRL}: o_wb_dat <= {30'h0, mode_q, start_q};
                {1'b0, TKS_OFS_MOD1}: o_wb_dat <= {24'h0, mod1_q};
                {1'b0, TKS_OFS_SLOT}: o_wb_dat <= {24'h0, slot_q};
                {1'b0, TKS_OFS_STAT}: o_wb_dat <= {26'h0, o_scan_key, slot_q2, ovf_q, busy_q};
                TKS_OFS_ISTAT:        o_wb_dat <= {30'h0, ev_q};
                TKS_OFS_IMASK:        o_wb_dat <= {30'h0, mask_q};
                default:              o_wb_dat <= 32'h0000_0000;
            endcase
        end
    end
    assign o_wb_ack = ack_q;

    // ************************************************************
    // control register: start and mode
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            start_q      <= 1'b0;
            mode_q       <= 1'b0;
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= start_q;
            if (wr && ofs == {1'b0, TKS_OFS_CTRL}) begin
                start_q <= i_wb_req.dat[TKS_CTRL_START];
                mode_q  <= i_wb_req.dat[TKS_CTRL_MODE];
            end
        end
    end

    // ************************************************************
    // slot select register
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            slot_q <= TKS_SLOT_RST;
        end else if (wr && ofs == {1'b0, TKS_OFS_SLOT}) begin
            slot_q <= i_wb_req.dat[7:0];
        end
    end

    // ************************************************************
    // module control one: key enables and oscillator enables
    // ************************************************************
    // hardware set/clear takes priority over a software write in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mod1_q <= TKS_MOD1_RST;
        end else begin
            // software write of the whole byte
            if (wr && ofs == {1'b0, TKS_OFS_MOD1}) begin
                mod1_q <= i_wb_req.dat[7:0];
            end
            // auto mode: start rise switches both oscillators on
            if (!mode_q && start_rise) begin
                mod1_q[TKS_M1_KOEN] <= 1'b1;
                mod1_q[TKS_M1_ROEN] <= 1'b1;
            end
            // end of scan: reference oscillator off, key oscillator too in auto mode
            if (busy_fall) begin
                // manual mode leaves the key oscillator to software
                if (!mode_q) begin
                    mod1_q[TKS_M1_KOEN] <= 1'b0;
                end
                mod1_q[TKS_M1_ROEN] <= 1'b0;
            end
        end
    end
    assign o_key_osc_enable = mod1_q[TKS_M1_KOEN];
    assign o_ref_osc_enable = mod1_q[TKS_M1_ROEN];

    // ************************************************************
    // scan sequencer: slots 0..3 in auto, single interval in manual
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            st_q        <= TKS_IDLE;
            busy_q      <= 1'b0;
            busy_prev_q <= 1'b0;
            slot_q2     <= 2'h0;
            dwell_q     <= 8'h00;
        end else begin
            busy_prev_q <= busy_q;
            unique case (st_q)
                TKS_IDLE: begin
                    // wait for the start bit to rise
                    if (start_rise) begin
                        st_q    <= TKS_SCAN;
                        busy_q  <= 1'b1;
                        slot_q2 <= 2'h0;
                        dwell_q <= TKS_SLOT_CYC;
                    end
                end
                TKS_SCAN: begin
                    // still inside the current slot
                    if (dwell_q > 8'h01) begin
                        dwell_q <= dwell_q - 8'h01;
                    // auto mode steps to the next slot
                    end else if (!mode_q && slot_q2 != 2'h3) begin
                        slot_q2 <= slot_q2 + 2'h1;
                        dwell_q <= TKS_SLOT_CYC;
                    // last slot, or the single manual interval, is over
                    end else begin
                        st_q   <= TKS_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                // unused encodings fall back to idle
                default: begin
                    st_q   <= TKS_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end
    assign o_scan_busy_flag = busy_q;
    assign o_slot           = slot_q2;
    // slot key only honoured in auto mode; manual holds key 0
    assign o_scan_key = mode_q ? 2'h0 : slot_key(slot_q, slot_q2);

    // ************************************************************
    // overflow flag and interrupt events
    // ************************************************************
    // set wins over a write-one clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ovf_q  <= 1'b0;
            ev_q   <= 2'h0;
            mask_q <= 2'h0;
        end else begin
            // a new scan forgets the last overflow
            if (start_rise) begin
                ovf_q <= 1'b0;
            end
            // only an auto scan runs out of slots
            if (busy_fall && !mode_q) begin
                ovf_q <= 1'b1;
            end
            // mask is plain storage
            if (wr && ofs == TKS_OFS_IMASK) begin
                mask_q <= i_wb_req.dat[1:0];
            end
            // write-one clear first, new events or in afterwards
            ev_q <= (ev_q & ~((wr && ofs == TKS_OFS_ISTAT) ? i_wb_req.dat[1:0] : 2'h0))
                    | {busy_fall, busy_fall & ~mode_q};
        end
    end
    assign o_slot_overflow_flag = ovf_q;
    assign o_irq                = |(ev_q & mask_q);
endmodule

/* tks_pkg.sv */
// package of constants and types for the touch key scan slot control slice
// How it works
// - auto mode: scan start rise sets key oscillator
// - auto mode: busy fall clears key oscillator
// - manual mode: busy fall clears reference oscillator
// - bits 5:4 pick slot 2 key
// - bits 3:2 pick slot 1 key
// - mode select low auto, high manual
// - auto mode scans slots 0 to 3
// - after four slots: overflow set, busy low
package tks_pkg;
    // ************************************************************
    // register map (word offsets, byte addresses)
    // ************************************************************
    localparam logic [3:0] TKS_OFS_CTRL   = 4'h0;  // control: start, mode
    localparam logic [3:0] TKS_OFS_MOD1   = 4'h4;  // module control one
    localparam logic [3:0] TKS_OFS_SLOT   = 4'h8;  // slot key select
    localparam logic [3:0] TKS_OFS_STAT   = 4'hC;  // status: busy, slot, key
    localparam logic [3:0] TKS_OFS_IRQ    = 4'h0;  // unused alias guard
    localparam logic [4:0] TKS_OFS_ISTAT  = 5'h10; // sticky event status
    localparam logic [4:0] TKS_OFS_IMASK  = 5'h14; // event mask
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TKS_CTRL_START  = 0;  // scan start bit
    localparam int TKS_CTRL_MODE   = 1;  // scan mode select
    localparam int TKS_M1_KOEN     = 4;  // key oscillator enable
    localparam int TKS_M1_ROEN     = 5;  // reference oscillator enable
    localparam int TKS_EV_OVF      = 0;  // slot overflow event
    localparam int TKS_EV_DONE     = 1;  // busy fell event
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] TKS_SLOT_RST  = 8'hE4; // slot3=3 slot2=2 slot1=1 slot0=0
    localparam logic [7:0] TKS_MOD1_RST  = 8'h00;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int TKS_SLOT_NS      = 64;                 // dwell per time slot
    localparam int TKS_CLK_MHZ      = 250;
    localparam logic [7:0] TKS_SLOT_CYC = 8'((TKS_SLOT_NS * TKS_CLK_MHZ) / 1000);
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] { TKS_IDLE, TKS_SCAN } tks_state_e;
    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } tks_wb_req_s;
endpackage

/* tks_slot_ctrl_checker.sv */
// assertions watching the slot control ports
module tks_slot_ctrl_checker (
    // clock, reset, bus
    input wire logic                 i_mclk,
    input wire logic                 i_sys_rst,
    input wire tks_pkg::tks_wb_req_s i_wb_req,
    input wire logic [31:0]          o_wb_dat,
    input wire logic                 o_wb_ack,
    // scan side
    input wire logic                 o_scan_busy_flag,
    input wire logic                 o_slot_overflow_flag,
    input wire logic [1:0]           o_slot,
    input wire logic [1:0]           o_scan_key,
    input wire logic                 o_key_osc_enable,
    input wire logic                 o_ref_osc_enable,
    input wire logic                 o_irq
);
    import tks_pkg::*;
    // ********
    // mirrors
    // ********
    logic       mode_q;  // 1 = manual
    logic [7:0] slot_q;  // slot select copy
    logic [7:0] run_q;   // busy run length
    wire        wr_acc = i_wb_req.cyc & i_wb_req.stb & i_wb_req.we & i_wb_req.sel[0] & o_wb_ack;
    // mirror writes at the ack edge, same edge the slave commits
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mode_q <= 1'b0;
            slot_q <= TKS_SLOT_RST;
        end else if (wr_acc && i_wb_req.adr[4:0] == 5'h00) begin
            mode_q <= i_wb_req.dat[1];
        end else if (wr_acc && i_wb_req.adr[4:0] == 5'h08) begin
            slot_q <= i_wb_req.dat[7:0];
        end
    end
    // counts busy cycles; 8 bits is enough for one auto scan
    always_ff @(posedge i_mclk) begin
        run_q <= (i_sys_rst || !o_scan_busy_flag) ? 8'h00 : run_q + 8'h01;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence s_auto_end;
        $fell(o_scan_busy_flag) && !mode_q;
    endsequence
    sequence s_koen_gone;
        ##[1:2] !o_key_osc_enable;
    endsequence
    property p_koen_on;
        $rose(o_scan_busy_flag) && !mode_q |-> o_key_osc_enable;
    endproperty
    property p_koen_off;
        s_auto_end |-> s_koen_gone;
    endproperty
    property p_ref_off;
        $fell(o_scan_busy_flag) && mode_q |-> ##[1:2] !o_ref_osc_enable;
    endproperty
    property p_ovf_set;
        s_auto_end |-> ##[0:2] o_slot_overflow_flag;
    endproperty
    property p_auto_len;
        s_auto_end |-> run_q == 8'h40;
    endproperty
    property p_slot_step;
        o_scan_busy_flag && $changed(o_slot) |-> o_slot == 2'($past(o_slot) + 2'h1);
    endproperty
    property p_key_map;
        o_scan_busy_flag && !mode_q |-> o_scan_key == slot_q[{o_slot, 1'b0} +: 2];
    endproperty
    property p_manual_key;
        o_scan_busy_flag && mode_q |-> o_scan_key == 2'h0;
    endproperty
    a_koen_on: assert property (p_koen_on) else $error("key osc not on at scan start");
    a_koen_off: assert property (p_koen_off) else $error("key osc not off at scan end");
    a_ref_off: assert property (p_ref_off) else $error("ref osc not off after manual scan");
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missing");
    a_auto_len: assert property (p_auto_len) else $error("auto scan length wrong");
    a_slot_step: assert property (p_slot_step) else $error("slot order wrong");
    a_key_map: assert property (p_key_map) else $error("slot key mismatch");
    a_manual_key: assert property (p_manual_key) else $error("manual key not zero");
endmodule
bind tks_slot_ctrl tks_slot_ctrl_checker u_chk (.i_mclk, .i_sys_rst, .i_wb_req, .o_wb_dat, .o_wb_ack,
    .o_scan_busy_flag, .o_slot_overflow_flag, .o_slot, .o_scan_key, .o_key_osc_enable, .o_ref_osc_enable, .o_irq);

/* tks_tb.sv */
// self-checking bench for the touch key slot control slice
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tks_pkg::*;
    logic        i_mclk, i_sys_rst, o_wb_ack, o_scan_busy_flag, o_slot_overflow_flag;
    logic        o_key_osc_enable, o_ref_osc_enable, o_irq;
    logic [1:0]  o_slot, o_scan_key;
    logic [31:0] o_wb_dat;
    tks_wb_req_s i_wb_req;    // bus request
    int          mismatches;  // failed compares
    int          checks_done; // compares made
    int          cycles;      // watchdog
    tks_slot_ctrl DUT (.i_mclk, .i_sys_rst, .i_wb_req, .o_wb_dat, .o_wb_ack, .o_scan_busy_flag,
        .o_slot_overflow_flag, .o_slot, .o_scan_key, .o_key_osc_enable, .o_ref_osc_enable, .o_irq);
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one classic cycle; holds the request until ack is sampled
    task automatic wb(input logic [4:0] a, input logic [7:0] d, input logic w, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_wb_req <= '{adr: {27'h0, a}, dat: {24'h0, d}, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
        @(posedge i_mclk);
        while (o_wb_ack !== 1'b1 && n < 50) begin
            n++;
            @(posedge i_mclk);
        end
        if (o_wb_ack !== 1'b1) mismatches++;
        r = o_wb_dat;
        i_wb_req <= '0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(a, d, 1'b1, r);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(a, 8'h00, 1'b0, r);
        chk(r, e);
    endtask
    // bounded wait for the scan to finish, then let clears land
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (4) @(posedge i_mclk);
        while (o_scan_busy_flag !== 1'b0 && n < 500) begin
            n++;
            @(posedge i_mclk);
        end
        if (o_scan_busy_flag !== 1'b0) mismatches++;
        repeat (3) @(posedge i_mclk);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop;
        end
    end
    initial begin
        i_sys_rst = 1'b1;
        i_wb_req = '0;
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(5'h08, 32'hE4);
        rd(5'h04, 32'h00);
        wr(5'h08, 8'h1B);
        rd(5'h08, 32'h1B);
        for (int i = 0; i < 4; i++) begin
            wr(5'h04, 8'(1 << i));
            rd(5'h04, 32'(1 << i));
        end
        wr(5'h18, 8'hFF);
        rd(5'h18, 32'h00);
        $display("test registers done");
        wr(5'h04, 8'h0F);
        wr(5'h14, 8'h03);
        wr(5'h00, 8'h01);
        rd(5'h04, 32'h3F);
        rd(5'h0C, 32'h31);
        chk({30'h0, o_scan_key}, 32'h3);
        repeat (14) @(posedge i_mclk);
        chk({30'h0, o_scan_key}, 32'h2);
        repeat (16) @(posedge i_mclk);
        chk({30'h0, o_slot}, 32'h2);
        chk({30'h0, o_scan_key}, 32'h1);
        wait_idle;
        rd(5'h04, 32'h0F);
        chk({31'h0, o_key_osc_enable}, 32'h0);
        chk({31'h0, o_ref_osc_enable}, 32'h0);
        chk({31'h0, o_slot_overflow_flag}, 32'h1);
        chk({31'h0, o_irq}, 32'h1);
        rd(5'h10, 32'h03);
        wr(5'h10, 8'h03);
        @(posedge i_mclk);
        chk({31'h0, o_irq}, 32'h0);
        $display("test auto scan done");
        wr(5'h00, 8'h00);
        wr(5'h04, 8'h3F);
        wr(5'h14, 8'h00);
        wr(5'h00, 8'h03);
        wait_idle;
        rd(5'h04, 32'h1F);
        chk({31'h0, o_ref_osc_enable}, 32'h0);
        chk({31'h0, o_key_osc_enable}, 32'h1);
        chk({31'h0, o_slot_overflow_flag}, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        rd(5'h10, 32'(1 << TKS_EV_DONE));
        wr(5'h14, 8'(1 << TKS_EV_DONE));
        @(posedge i_mclk);
        chk({31'h0, o_irq}, 32'h1);
        $display("test manual scan done");
        report_and_stop;
    end
endmodule
